// >>> core/asp_axis_stop_core.sv
/*
 Two-axis stop supervision, logical coordinate and encoder counter,
 with a simple pulse generator and an AHB-Lite register slave.
 Assumes the axis, all-stop and silence pins are asynchronous to CLK and that the AHB master
 issues single word transfers only.
*/
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_axis_stop_core (
    input  wire logic                         CLK,
    input  wire logic                         RESET,
    input  wire logic                         HSEL,
    input  wire logic [11:0]                  HADDR,
    input  wire logic [1:0]                   HTRANS,
    input  wire logic                         HWRITE,
    input  wire logic [2:0]                   HSIZE,
    input  wire logic [31:0]                  HWDATA,
    input  wire logic                         HREADY,
    output logic      [31:0]                  HRDATA,
    output logic                              HREADYOUT,
    output logic                              HRESP,
    input  wire logic                         ALL_STOP,
    input  wire logic                         NETWORK_SILENCE,
    input  wire asp_pkg::asp_axis_in_s [1:0]  AXIS_IN,
    output asp_pkg::asp_axis_out_s     [1:0]  AXIS_OUT
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [9:0] a,
                                     input logic       axis,
                                     input logic [2:0] idx);
        reg_hit = (a[9:4] == 6'h00) && (a[`ASP_AXIS_BIT] == axis)
                  && (a[2:0] == idx);
    endfunction : reg_hit

    function automatic asp_pkg::asp_stop_s stop_chk(
        input asp_pkg::asp_pg2_s     pg,
        input asp_pkg::asp_axis_in_s p,
        input logic                  all,
        input logic                  sil,
        input logic                  dir,
        input logic                  exp,
        input logic                  exn,
        input logic                  top);
        asp_pkg::asp_stop_s r;
        logic c_net;
        logic c_sen;
        logic c_lim;
        r     = '{imm: 1'b0, dec: 1'b0, cause: asp_pkg::ASP_C_NONE};
        c_net = pg.net_en & sil;
        c_sen = pg.in23_fs & (dir ? p.gin[2] : p.gin[3]);
        c_lim = pg.lim_en & (dir ? exp : exn);
        if (all) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_ALL};
        end else if (dir ? p.limit_p : p.limit_n) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_HWLIM};
        end else if (pg.in1_fs & p.gin[1]) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_SIG};
        end else if (c_net & (~pg.net_decel | top)) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_NET};
        end else if (c_sen & ~pg.sens_decel) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_SENS};
        end else if (c_lim & ~pg.lim_decel) begin
            r = '{imm: 1'b1, dec: 1'b0, cause: asp_pkg::ASP_C_LIMC};
        end else if (c_net) begin
            r = '{imm: 1'b0, dec: 1'b1, cause: asp_pkg::ASP_C_NET};
        end else if (c_sen) begin
            r = '{imm: 1'b0, dec: 1'b1, cause: asp_pkg::ASP_C_SENS};
        end else if (c_lim) begin
            r = '{imm: 1'b0, dec: 1'b1, cause: asp_pkg::ASP_C_LIMC};
        end
        return r;
    endfunction : stop_chk

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [19:0]                 sync1_ff;
    logic [19:0]                 sync2_ff;
    asp_pkg::asp_axis_in_s [1:0] pin;
    logic                        all_stop;
    logic                        silence;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync1_ff <= 20'h00000;
            sync2_ff <= 20'h00000;
        end else begin
            sync1_ff <= {ALL_STOP, NETWORK_SILENCE, AXIS_IN};
            sync2_ff <= sync1_ff;
        end
    end

    assign pin      = sync2_ff[17:0];
    assign silence  = sync2_ff[18];
    assign all_stop = sync2_ff[19];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Reads take one wait state so that a read right behind a write
    // to the same register already sees the new value.
    logic        addr_ph;
    logic        wr_ff;
    logic        rd_ff;
    logic [9:0]  addr_ff;
    logic        rdy_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    logic [31:0] rdv [2][8];

    assign addr_ph = HSEL & HTRANS[1] & HREADY;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            addr_ff  <= 10'h000;
            rdy_ff   <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_ff  <= addr_ph & HWRITE;
            rd_ff  <= addr_ph & ~HWRITE;
            rdy_ff <= ~(addr_ph & ~HWRITE);
            if (addr_ph) begin
                addr_ff <= HADDR[11:2];
            end
            if (rd_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_ff[9:4] == 6'h00) begin
            rd_mux = rdv[addr_ff[`ASP_AXIS_BIT]][addr_ff[2:0]];
        end
    end

    assign HRDATA    = rdata_ff;
    assign HREADYOUT = rdy_ff;
    assign HRESP     = 1'b0;

    // ------------------------------------------------------------
    // Per-axis logic
    // ------------------------------------------------------------
    genvar ax;
    generate
        for (ax = 0; ax < 2; ax++) begin : g_axis
            asp_pkg::asp_pg2_s   pg2_ff;
            logic [23:0]         lpc_ff;
            logic [23:0]         ppc_ff;
            logic [23:0]         limp_ff;
            logic [23:0]         limn_ff;
            logic [31:0]         speed_ff;
            asp_pkg::asp_state_e st_ff;
            asp_pkg::asp_op_e    op_ff;
            asp_pkg::asp_cause_e cause_ff;
            logic                dir_ff;
            logic                top_ff;
            logic                err_ff;
            logic                pulse_ff;
            logic [15:0]         per_ff;
            logic [15:0]         cnt_ff;
            logic                org_prev_ff;
            logic                ez_prev_ff;
            logic                ea_prev_ff;
            logic                eb_prev_ff;
            logic                we_pg2;
            logic                we_lpc;
            logic                we_limp;
            logic                we_limn;
            logic                we_spd;
            logic                we_cmd;
            asp_pkg::asp_op_e    cmd_op;
            logic                is_start;
            logic                sdir;
            logic                moving;
            logic                step;
            logic [23:0]         cmp;
            logic                exp;
            logic                exn;
            logic                home_hit;
            logic                reject;
            logic [15:0]         run_per;
            asp_pkg::asp_stop_s  chk_run;
            asp_pkg::asp_stop_s  chk_st;

            assign we_pg2  = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_PG2);
            assign we_lpc  = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_LPC);
            assign we_limp = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_LIMP);
            assign we_limn = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_LIMN);
            assign we_spd  = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_SPEED);
            assign we_cmd  = wr_ff & reg_hit(addr_ff, 1'(ax), `ASP_IDX_CMD);
            assign cmd_op  = asp_pkg::asp_op_e'(HWDATA[2:0]);

            assign is_start = (cmd_op != asp_pkg::ASP_NOP)
                              && (cmd_op != asp_pkg::ASP_STOP_I)
                              && (cmd_op != asp_pkg::ASP_STOP_D);
            // Homing heads toward logical zero.
            assign sdir = (cmd_op == asp_pkg::ASP_MOVE_P)
                        | ((cmd_op != asp_pkg::ASP_MOVE_N)
                           & (lpc_ff[23] | (lpc_ff == 24'h000000)));
            assign moving  = (st_ff != asp_pkg::ASP_IDLE);
            assign step    = moving & (cnt_ff == 16'h0000);
            assign run_per = (speed_ff[15:0] == 16'h0000) ? 16'h0001
                                                          : speed_ff[15:0];

            assign cmp = pg2_ff.lim_src ? ppc_ff : lpc_ff;
            assign exp = $signed(cmp) >= $signed(limp_ff);
            assign exn = $signed(cmp) <= $signed(limn_ff);

            assign chk_run = stop_chk(pg2_ff, pin[ax], all_stop, silence,
                                      dir_ff, exp, exn, top_ff);
            assign chk_st  = stop_chk(pg2_ff, pin[ax], all_stop, silence,
                                      sdir, exp, exn, 1'b0);

            // Origin sensor only for homing one and two, zero input only
            // for homing three.
            always_comb begin
                home_hit = 1'b0;
                unique case (op_ff)
                    asp_pkg::ASP_HOME1: home_hit = pin[ax].origin & ~org_prev_ff;
                    asp_pkg::ASP_HOME2: home_hit = ~pin[ax].origin & org_prev_ff;
                    asp_pkg::ASP_HOME3: home_hit = pin[ax].gin[0] & ~ez_prev_ff;
                    default:            home_hit = 1'b0;
                endcase
            end

            assign reject = chk_st.imm | chk_st.dec
                          | (pg2_ff.lim_en & (exp | exn))
                          | ((cmd_op == asp_pkg::ASP_HOME1) & pin[ax].origin)
                          | ((cmd_op == asp_pkg::ASP_HOME3) & pin[ax].gin[0]);

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    pg2_ff   <= `ASP_PG2_RST;
                    limp_ff  <= `ASP_LIMP_RST;
                    limn_ff  <= `ASP_LIMN_RST;
                    speed_ff <= `ASP_SPEED_RST;
                end else begin
                    if (we_pg2) begin
                        pg2_ff <= HWDATA[7:0];
                    end
                    if (we_limp) begin
                        limp_ff <= HWDATA[23:0];
                    end
                    if (we_limn) begin
                        limn_ff <= HWDATA[23:0];
                    end
                    if (we_spd) begin
                        speed_ff <= HWDATA;
                    end
                end
            end

            // A software load wins over a pulse in the same cycle.
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    lpc_ff <= 24'h000000;
                end else if (we_lpc) begin
                    lpc_ff <= HWDATA[23:0];
                end else if (step) begin
                    lpc_ff <= dir_ff ? lpc_ff + 24'h000001 : lpc_ff - 24'h000001;
                end
            end

            // Both phases changing together is a missed count and is
            // dropped rather than guessed.
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    ppc_ff     <= 24'h000000;
                    ea_prev_ff <= 1'b0;
                    eb_prev_ff <= 1'b0;
                end else begin
                    ea_prev_ff <= pin[ax].enc_a;
                    eb_prev_ff <= pin[ax].enc_b;
                    if ((pin[ax].enc_a ^ ea_prev_ff) ^ (pin[ax].enc_b ^ eb_prev_ff)) begin
                        ppc_ff <= (pin[ax].enc_a ^ eb_prev_ff) ? ppc_ff + 24'h000001
                                                               : ppc_ff - 24'h000001;
                    end
                end
            end

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    org_prev_ff <= 1'b0;
                    ez_prev_ff  <= 1'b0;
                end else begin
                    org_prev_ff <= pin[ax].origin;
                    ez_prev_ff  <= pin[ax].gin[0];
                end
            end

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    cnt_ff   <= 16'h0000;
                    pulse_ff <= 1'b0;
                end else begin
                    pulse_ff <= step;
                    if (!moving) begin
                        cnt_ff <= run_per - 16'h0001;
                    end else if (step) begin
                        cnt_ff <= per_ff - 16'h0001;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
            end

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    st_ff    <= asp_pkg::ASP_IDLE;
                    op_ff    <= asp_pkg::ASP_NOP;
                    cause_ff <= asp_pkg::ASP_C_NONE;
                    dir_ff   <= 1'b1;
                    top_ff   <= 1'b0;
                    err_ff   <= 1'b0;
                    per_ff   <= 16'h0001;
                end else begin
                    unique case (st_ff)
                        asp_pkg::ASP_IDLE: begin
                            if (we_cmd && is_start && reject) begin
                                err_ff <= 1'b1;
                            end else if (we_cmd && is_start) begin
                                st_ff    <= asp_pkg::ASP_RUN;
                                op_ff    <= cmd_op;
                                dir_ff   <= sdir;
                                top_ff   <= HWDATA[3];
                                per_ff   <= run_per;
                                err_ff   <= 1'b0;
                                cause_ff <= asp_pkg::ASP_C_NONE;
                            end
                        end
                        asp_pkg::ASP_RUN, asp_pkg::ASP_DECEL: begin
                            if (we_cmd && is_start) begin
                                err_ff <= 1'b1;
                            end
                            if (chk_run.imm) begin
                                st_ff    <= asp_pkg::ASP_IDLE;
                                op_ff    <= asp_pkg::ASP_NOP;
                                cause_ff <= chk_run.cause;
                            end else if (home_hit) begin
                                st_ff    <= asp_pkg::ASP_IDLE;
                                op_ff    <= asp_pkg::ASP_NOP;
                                cause_ff <= asp_pkg::ASP_C_HOME;
                            end else if (we_cmd && cmd_op == asp_pkg::ASP_STOP_I) begin
                                st_ff    <= asp_pkg::ASP_IDLE;
                                op_ff    <= asp_pkg::ASP_NOP;
                                cause_ff <= asp_pkg::ASP_C_SW;
                            end else if (st_ff == asp_pkg::ASP_RUN) begin
                                if (chk_run.dec) begin
                                    st_ff    <= asp_pkg::ASP_DECEL;
                                    cause_ff <= chk_run.cause;
                                end else if (we_cmd && cmd_op == asp_pkg::ASP_STOP_D) begin
                                    st_ff    <= asp_pkg::ASP_DECEL;
                                    cause_ff <= asp_pkg::ASP_C_SW;
                                end
                            end else if (step) begin
                                // Ramp down by stretching the period until
                                // the lower-speed period is reached.
                                if (per_ff >= speed_ff[31:16]) begin
                                    st_ff <= asp_pkg::ASP_IDLE;
                                    op_ff <= asp_pkg::ASP_NOP;
                                end else begin
                                    per_ff <= per_ff + `ASP_DECEL_STEP;
                                end
                            end
                        end
                        default: begin
                            st_ff <= asp_pkg::ASP_IDLE;
                        end
                    endcase
                end
            end

            assign AXIS_OUT[ax].pulse = pulse_ff;
            assign AXIS_OUT[ax].dir   = dir_ff;

            assign rdv[ax][0] = {24'h000000, pg2_ff};
            assign rdv[ax][1] = {{8{lpc_ff[23]}}, lpc_ff};
            assign rdv[ax][2] = {{8{ppc_ff[23]}}, ppc_ff};
            assign rdv[ax][3] = {{8{limp_ff[23]}}, limp_ff};
            assign rdv[ax][4] = {{8{limn_ff[23]}}, limn_ff};
            assign rdv[ax][5] = speed_ff;
            assign rdv[ax][6] = {28'h0000000, top_ff, op_ff};
            assign rdv[ax][7] = {23'h000000, st_ff, dir_ff, cause_ff,
                                 err_ff, moving};
        end
    endgenerate

endmodule : asp_axis_stop_core

// >>> pkg/asp_params.svh
/*
 Register offsets, reset values and timing constants of the
 two-axis stop supervision and position block.
 Assumes a 32-bit AHB-Lite slave port and a 100 MHz CLK.
*/
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

`define ASP_IDX_PG2    3'h0
`define ASP_IDX_LPC    3'h1
`define ASP_IDX_PPC    3'h2
`define ASP_IDX_LIMP   3'h3
`define ASP_IDX_LIMN   3'h4
`define ASP_IDX_SPEED  3'h5
`define ASP_IDX_CMD    3'h6
`define ASP_IDX_STAT   3'h7
`define ASP_AXIS_BIT   3
`define ASP_PG2_RST    8'hE9
`define ASP_LIMP_RST   24'h7FFFFF
`define ASP_LIMN_RST   24'h800000
`define ASP_SPEED_RST  32'h0400_0040
`define ASP_DECEL_STEP 16'h0010

`endif

// >>> pkg/asp_pkg.sv
/*
 Types shared by the stop supervision block.
 Assumes nothing of its surroundings.
*/
package asp_pkg;

    typedef struct packed {
        logic       limit_p;
        logic       limit_n;
        logic       origin;
        logic [3:0] gin;
        logic       enc_a;
        logic       enc_b;
    } asp_axis_in_s;

    typedef struct packed {
        logic pulse;
        logic dir;
    } asp_axis_out_s;

    typedef struct packed {
        logic lim_decel;
        logic sens_decel;
        logic net_decel;
        logic lim_src;
        logic lim_en;
        logic in23_fs;
        logic in1_fs;
        logic net_en;
    } asp_pg2_s;

    typedef enum logic [1:0] {
        ASP_IDLE  = 2'b00,
        ASP_RUN   = 2'b01,
        ASP_DECEL = 2'b10
    } asp_state_e;

    typedef enum logic [2:0] {
        ASP_NOP    = 3'b000,
        ASP_MOVE_P = 3'b001,
        ASP_MOVE_N = 3'b010,
        ASP_HOME1  = 3'b011,
        ASP_HOME2  = 3'b100,
        ASP_HOME3  = 3'b101,
        ASP_STOP_I = 3'b110,
        ASP_STOP_D = 3'b111
    } asp_op_e;

    typedef enum logic [3:0] {
        ASP_C_NONE  = 4'h0,
        ASP_C_ALL   = 4'h1,
        ASP_C_NET   = 4'h2,
        ASP_C_HWLIM = 4'h3,
        ASP_C_SIG   = 4'h4,
        ASP_C_SENS  = 4'h5,
        ASP_C_LIMC  = 4'h6,
        ASP_C_HOME  = 4'h7,
        ASP_C_SW    = 4'h8
    } asp_cause_e;

    typedef struct packed {
        logic       imm;
        logic       dec;
        asp_cause_e cause;
    } asp_stop_s;

endpackage : asp_pkg

// >>> verif/asp_axis_stop_checker.sv
/* Assertions on the ports of the stop supervision core.
   Assumes a bind from the core scope with port names matching. */
`timescale 1ns/10ps

module asp_axis_stop_checker (
    input wire logic                        CLK,
    input wire logic                        RESET,
    input wire logic                        HSEL,
    input wire logic [1:0]                  HTRANS,
    input wire logic                        HWRITE,
    input wire logic                        HREADY,
    input wire logic [31:0]                 HRDATA,
    input wire logic                        HREADYOUT,
    input wire logic                        HRESP,
    input wire logic                        ALL_STOP,
    input wire asp_pkg::asp_axis_in_s [1:0] AXIS_IN,
    input wire asp_pkg::asp_axis_out_s [1:0] AXIS_OUT
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    wire take = HSEL && HTRANS[1] && HREADY;
    sequence s_rd_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    // Six cycles cover the two sync stages, the stop decision and the pulse flop.
    a_allstop_halts_all: assert property (ALL_STOP[*6] |-> !AXIS_OUT[0].pulse && !AXIS_OUT[1].pulse)
        else $error("pulse while all-stop held");
    a_plus_limit_halts: assert property ((AXIS_IN[0].limit_p && AXIS_OUT[0].dir)[*6] |-> !AXIS_OUT[0].pulse)
        else $error("plus limit ignored");
    a_minus_limit_halts: assert property ((AXIS_IN[1].limit_n && !AXIS_OUT[1].dir)[*6] |-> !AXIS_OUT[1].pulse)
        else $error("minus limit ignored");
    a_reset_quiet_out: assert property (disable iff (1'b0) RESET |=> !AXIS_OUT[0].pulse && AXIS_OUT[0].dir && HREADYOUT)
        else $error("outputs not quiet after reset");
    a_read_one_wait: assert property (take && !HWRITE |=> s_rd_wait)
        else $error("read data phase not two cycles");
    a_write_no_wait: assert property (take && HWRITE |=> HREADYOUT)
        else $error("write data phase stalled");
    a_rdata_holds_value: assert property ($changed(HRDATA) |-> !$past(HREADYOUT))
        else $error("read data moved outside a read");
    a_resp_always_okay: assert property (HRESP == 1'b0)
        else $error("response not okay");
endmodule : asp_axis_stop_checker

bind asp_axis_stop_core asp_axis_stop_checker asp_axis_stop_checker_i (.*);

// >>> verif/asp_motor_model.sv
/* Motor driver, limit switches and encoder of one axis.
   Assumes one pulse per step and dir high for the positive way. */
`timescale 1ns/10ps

module asp_motor_model #(
    parameter int LIM = 16
) (
    input wire logic                   CLK,
    input wire logic                   RESET,
    input wire asp_pkg::asp_axis_out_s drv,
    input wire logic                   origin,
    output asp_pkg::asp_axis_in_s      sense,
    output logic [31:0]                pos
);
    // ----------------------------------------
    // Mechanics
    // ----------------------------------------
    logic [1:0] ph = 2'h0;
    initial pos = 32'h0;
    // One quadrature step per pulse, so the encoder count must equal the step count.
    always @(posedge CLK) begin
        if (RESET) begin
            pos <= 32'h0;
        end else if (drv.pulse) begin
            pos <= drv.dir ? pos + 32'h1 : pos - 32'h1;
            ph <= drv.dir ? ph + 2'h1 : ph - 2'h1;
        end
    end
    assign sense = {$signed(pos) >= LIM, $signed(pos) <= -LIM, origin, 4'h0, ^ph, ph[1]};
endmodule : asp_motor_model

// >>> verif/test_axis_stop_and_position_control.sv
/* Self-checking bench of the stop supervision core.
   Assumes the core, its package, the checker and the motor model. */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module test_axis_stop_and_position_control;
    logic                         CLK, RESET, HSEL, HWRITE, ALL_STOP, NETWORK_SILENCE, HRESP, HREADYOUT, org0;
    logic [11:0]                  HADDR;
    logic [1:0]                   HTRANS;
    logic [31:0]                  HWDATA, HRDATA, q;
    logic [1:0][31:0]             pos;
    wire                          HREADY = HREADYOUT;
    wire [2:0]                    HSIZE = 3'h2;
    asp_pkg::asp_axis_in_s [1:0]  AXIS_IN;
    asp_pkg::asp_axis_out_s [1:0] AXIS_OUT;
    int                           bad_count = 0, num_checks = 0, cyc = 0;

    asp_axis_stop_core asp_axis_stop_core_i (.*);
    asp_motor_model asp_motor_model_i [1:0] (.CLK(CLK), .RESET(RESET), .drv(AXIS_OUT),
        .origin({1'b0, org0}), .sense(AXIS_IN), .pos(pos));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Ready is looked at on the falling edge, where the registered value is settled.
    task automatic rdy;
        @(negedge CLK);
        while (!HREADY) @(negedge CLK);
        @(posedge CLK);
    endtask : rdy
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        rdy;
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdy;
        q = HRDATA;
    endtask : bus
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rdchk
    task automatic go(input logic [11:0] b, input logic [3:0] c, input logic [5:0] m, e);
        bus(1'b1, b | 12'h018, {28'h0, c});
        do bus(1'b0, b | 12'h01C, 32'h0); while (q[0] !== 1'b0);
        `CHK(q[5:0] & m, e)
    endtask : go
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic t_reset;
        rdchk(12'h000, 32'h0000_00E9);
        rdchk(12'h020, 32'h0000_00E9);
        rdchk(12'h004, 32'h0);
        rdchk(12'h02C, 32'h007F_FFFF);
        rdchk(12'h030, 32'hFF80_0000);
        rdchk(12'h040, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_axis0;
        bus(1'b1, 12'h014, 32'h0040_0004);
        go(12'h000, 4'h1, 6'h3F, 6'h0C);
        rdchk(12'h008, pos[0]);
        go(12'h000, 4'h1, 6'h03, 6'h02);
        org0 <= 1'b1;
        repeat (4) @(posedge CLK);
        go(12'h000, 4'h3, 6'h03, 6'h02);
        bus(1'b1, 12'h004, 32'h00FF_FFF0);
        rdchk(12'h004, 32'hFFFF_FFF0);
        bus(1'b1, 12'h004, 32'h0);
        rdchk(12'h004, 32'h0);
        $display("axis zero test done");
    endtask : t_axis0
    task automatic t_axis1;
        bus(1'b1, 12'h034, 32'h0040_0004);
        ALL_STOP <= 1'b1;
        repeat (4) @(posedge CLK);
        go(12'h020, 4'h2, 6'h03, 6'h02);
        ALL_STOP <= 1'b0;
        NETWORK_SILENCE <= 1'b1;
        repeat (4) @(posedge CLK);
        go(12'h020, 4'h2, 6'h03, 6'h02);
        NETWORK_SILENCE <= 1'b0;
        repeat (4) @(posedge CLK);
        fork
            begin
                repeat (40) @(posedge CLK);
                ALL_STOP <= 1'b1;
            end
        join_none
        go(12'h020, 4'h1, 6'h3F, 6'h04);
        ALL_STOP <= 1'b0;
        bus(1'b1, 12'h030, 32'hFFFF_FFFC);
        go(12'h020, 4'h2, 6'h3F, 6'h18);
        go(12'h020, 4'h2, 6'h03, 6'h02);
        bus(1'b1, 12'h020, 32'h0000_00E1);
        go(12'h020, 4'h2, 6'h3F, 6'h0C);
        rdchk(12'h024, pos[1]);
        $display("axis one test done");
    endtask : t_axis1

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        RESET = 1'b1;
        {HSEL, HWRITE, ALL_STOP, NETWORK_SILENCE, org0, HADDR, HTRANS, HWDATA} = '0;
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        t_reset;
        t_axis0;
        t_axis1;
        report_and_stop;
    end
endmodule : test_axis_stop_and_position_control
